// file: bench/itc_props.sv
// itc_props: bus handshake and clock gating checks on the itc_top ports.
// assumes bound into itc_top; one clock domain.
`timescale 1ns/1ps
module itc_props
  import itc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // cpu and clock outputs
  input wire logic stop_req,
  input wire logic sub_clk_sel,
  input wire logic main_osc_en,
  input wire logic periph_clk_en,
  input wire logic [itc_pkg::PDIV_W-1:0] periph_div_taps
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_wait_one_state: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait state");
  a_wait_single_cycle: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer stood too long");
  a_rdata_on_answer: assert property (!$stable(avs_readdata) |-> !avs_waitrequest)
    else $error("read data moved outside an answer");
  a_osc_stop_sub: assert property (!main_osc_en |-> sub_clk_sel)
    else $error("main oscillator stopped on main clock");
  a_stop_gates_clock: assert property ($rose(stop_req) |-> ##[1:8] !periph_clk_en)
    else $error("stop did not gate the clock");
  a_stop_exit_clock: assert property ($fell(stop_req) |-> ##[1:8] periph_clk_en)
    else $error("clock not restored after stop");
  a_taps_zero_stop: assert property (!periph_clk_en [*2] |-> periph_div_taps == '0)
    else $error("divider taps running in stop");
  a_taps_run_free: assert property (!stop_req [*8] ##1 periph_clk_en [*2] |-> periph_div_taps[0] != $past(periph_div_taps[0]))
    else $error("first tap not toggling");
endmodule : itc_props
bind itc_top itc_props u_props (.clk, .resetn, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .stop_req, .sub_clk_sel, .main_osc_en, .periph_clk_en, .periph_div_taps);

// file: bench/tb_top.sv
// tb_top: self-checking bench for itc_top: counter rates, overflow irq, clock mode, stop.
// assumes itc_props is bound into the design; 250 MHz clock.
`timescale 1ns/1ps
module tb_top;
  import itc_pkg::*;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [11:0] avs_address = 12'h0;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic stop_req = 1'h0;
  logic irq_ack = 1'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, sub_clk_sel, main_osc_en, periph_clk_en, irq;
  logic [1:0] sys_clk_choice;
  logic [11:0] periph_div_taps;
  logic [31:0] q;
  int mismatches = 0;
  int check_count = 0;
  int seed = 93;
  itc_top dut (.clk, .resetn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .stop_req, .irq_ack, .sub_clk_sel, .main_osc_en, .sys_clk_choice, .periph_clk_en,
    .periph_div_taps, .irq);
  initial
  begin
    forever #2 clk = ~clk;
  end
  task tally_and_finish;
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // the prescaler phase is free, so a count is only known to within one tick
  task rng(input string nm, input int lo, input int hi, input logic [31:0] got);
    check_count++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      mismatches++;
      $display("unexpected %s: expected %0d..%0d seen %h", nm, lo, hi, got);
    end
  endtask : rng
  task bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= d;
    // look at waitrequest mid-cycle, so the register update on the edge cannot race the sample
    do
    begin
      @(negedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'h0 && n < 64);
    @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (n >= 64)
    begin
      mismatches++;
      tally_and_finish;
    end
  endtask : bus
  function logic [3:0] mode_pins(input logic [3:0] m);
    return {m[1], ~(m[1] & m[0]), m[3:2]};
  endfunction : mode_pins
  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'h1;
    chk("clock choice", 32'h0, {sub_clk_sel, sys_clk_choice});
    repeat (4096) @(posedge clk);
    bus(OFF_COUNT_CTRL, 1'h0, 32'h0);
    rng("count after reset", 3, 5, q);
    for (int k = 0; k < 8; k++)
    begin
      bus(OFF_COUNT_CTRL, 1'h1, ($random(seed) & 32'hfffffff0) | 32'h8 | 32'(k));
      repeat (4 << (k + 3)) @(posedge clk);
      bus(OFF_COUNT_CTRL, 1'h0, 32'h0);
      rng("count", 3, 5, q);
    end
    bus(OFF_COUNT_CTRL, 1'h1, 32'h8);
    repeat (2100) @(posedge clk);
    chk("masked irq", 32'h0, irq);
    bus(OFF_IRQ_MASK, 1'h1, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, irq);
    bus(OFF_IRQ_STATUS, 1'h0, 32'h0);
    chk("status", 32'h1, q);
    repeat (3) @(posedge clk);
    chk("irq after read", 32'h0, irq);
    repeat (2048) @(posedge clk);
    chk("irq held", 32'h1, irq);
    irq_ack <= 1'h1;
    @(posedge clk);
    irq_ack <= 1'h0;
    repeat (3) @(posedge clk);
    chk("irq after ack", 32'h0, irq);
    for (int m = 0; m < 16; m++)
    begin
      bus(OFF_SYSCLK_MODE, 1'h1, 32'(m));
      repeat (2) @(posedge clk);
      chk("mode pins", mode_pins(4'(m)), {sub_clk_sel, main_osc_en, sys_clk_choice});
      bus(OFF_SYSCLK_MODE, 1'h0, 32'h0);
      chk("mode reg", 32'(m), q);
    end
    bus(12'h100, 1'h0, 32'h0);
    chk("unmapped", 32'h0, q);
    stop_req <= 1'h1;
    repeat (12) @(posedge clk);
    chk("stop gate", 32'h0, {periph_clk_en, periph_div_taps});
    bus(OFF_STOP_CTRL, 1'h0, 32'h0);
    chk("stop state", 32'h1, q);
    stop_req <= 1'h0;
    repeat (12) @(posedge clk);
    chk("stop exit", 32'h1, periph_clk_en);
    bus(OFF_IRQ_STATUS, 1'h0, 32'h0);
    chk("wake status", 32'h2, q & 32'h2);
    tally_and_finish;
  end
endmodule : tb_top

// file: logic/itc_pkg.sv
// itc_pkg: register map, field layout, reset values and timing constants of the interval timer / clock generator.
// assumes a 32-bit avalon-mm slave with word addressing at byte offsets.
package itc_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_COUNT_CTRL = 12'h0e6;
  localparam logic [11:0] OFF_SYSCLK_MODE = 12'h0e8;
  localparam logic [11:0] OFF_IRQ_STATUS = 12'h0ec;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h0f0;
  localparam logic [11:0] OFF_STOP_CTRL = 12'h0f4;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 2;
  localparam int CLR_BIT = 3;
  localparam logic [2:0] SEL_RESET = 3'h7;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam int MODE_MAIN_STOP = 0;
  localparam int MODE_SUB_SEL = 1;
  localparam int PRE_SHIFT_BASE = 3;
  localparam int PRE_W = 10;
  localparam int PDIV_W = 12;
  localparam logic [7:0] COUNT_MAX = 8'hff;
  // two events: overflow and stop-mode exit
  localparam int IRQ_W = 2;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_WAKE = 1;
  typedef enum logic [1:0] {ITC_IDLE = 2'b00, ITC_RESP = 2'b01} itc_bus_e;
endpackage : itc_pkg

// file: logic/itc_prescaler.sv
// itc_prescaler: free divider chain of the main clock, tick select and peripheral divide taps.
// assumes clk is the main clock; run low gates the chain (stop mode).
`timescale 1ns/1ps
module itc_prescaler
  import itc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control
  itc_tick_if.div tk
);
  logic [PDIV_W-1:0] cnt_reg;
  logic [PDIV_W-1:0] cnt_next;
  logic [PDIV_W-1:0] carry;
  logic tick_reg;
  wire [3:0] tap_idx = 4'(tk.sel) + 4'(PRE_SHIFT_BASE);
  assign cnt_next = cnt_reg + 12'h001;
  // a tap divides by 2^n when its lower bits roll over
  genvar g;
  generate
    for (g = 0; g < PDIV_W; g++)
    begin : g_carry
      assign carry[g] = &cnt_reg[g:0];
    end
  endgenerate
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt_reg <= 12'h000;
      tick_reg <= 1'b0;
    end
    else if (tk.run)
    begin
      cnt_reg <= cnt_next;
      tick_reg <= carry[tap_idx - 4'h1];
    end
    else
      tick_reg <= 1'b0;
  end
  assign tk.tick = tick_reg;
  assign tk.pdiv = cnt_reg & {PDIV_W{tk.run}};
endmodule : itc_prescaler

// file: logic/itc_tick_if.sv
// itc_tick_if: prescaler select in, prescaled tick out, between top and divider.
// assumes one clock domain.
`timescale 1ns/1ps
interface itc_tick_if;
  logic [2:0] sel;
  logic run;
  logic tick;
  logic [11:0] pdiv;
  modport ctl (output sel, output run, input tick, input pdiv);
  modport div (input sel, input run, output tick, output pdiv);
endinterface : itc_tick_if

// file: logic/itc_top.sv
// itc_top: interval timer with shared count/control address, system clock mode and irq over avalon-mm.
// assumes clk is the main clock and the cpu raises stop_req while executing its stop instruction.
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/1ps
module itc_top
  import itc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // avalon-mm slave
  input wire logic [itc_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // cpu side
  input wire logic stop_req,
  input wire logic irq_ack,
  // clock generator outputs and irq
  output logic sub_clk_sel,
  output logic main_osc_en,
  output logic [1:0] sys_clk_choice,
  output logic periph_clk_en,
  output logic [itc_pkg::PDIV_W-1:0] periph_div_taps,
  output logic irq
);
  import itc_pkg::*;

  itc_tick_if tk ();
  itc_bus_e bus_reg;
  logic [7:0] count_reg;
  logic [2:0] sel_reg;
  logic clr_reg;
  logic [3:0] mode_reg;
  logic [IRQ_W-1:0] stat_reg;
  logic [IRQ_W-1:0] stat_next;
  logic [IRQ_W-1:0] mask_reg;
  logic stop_reg;
  logic [2:0] stop_sync_reg;
  logic [31:0] rdata_reg;
  logic [PDIV_W-1:0] taps_reg;
  logic irq_reg;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] off);
    hit = (a == off[ADDR_W-1:0]);
  endfunction : hit

  // one wait cycle per access: the answer comes the edge after the request is seen
  wire req = (avs_read | avs_write) & (bus_reg == ITC_IDLE);
  wire wr = avs_write & req;
  wire rd = avs_read & req;
  wire wr_ctrl = wr & hit(avs_address, OFF_COUNT_CTRL);
  wire wr_mode = wr & hit(avs_address, OFF_SYSCLK_MODE);
  wire wr_mask = wr & hit(avs_address, OFF_IRQ_MASK);
  wire rd_stat = rd & hit(avs_address, OFF_IRQ_STATUS);
  // stop_req is a pin from the cpu core: take it after three flops, change on agreement of the last two
  wire stop_seen = (stop_sync_reg[2] == stop_sync_reg[1]) ? stop_sync_reg[1] : stop_reg;
  wire wake_evt = stop_reg & ~stop_seen;
  wire ovf_evt = tk.tick & ~clr_reg & (count_reg == COUNT_MAX);
  wire [IRQ_W-1:0] evt = {wake_evt, ovf_evt};
  wire [IRQ_W-1:0] ack_clr = {1'b0, irq_ack};

  // set wins over a read clear or an acknowledge in the same cycle
  assign stat_next = (stat_reg & ~(rd_stat ? {IRQ_W{1'b1}} : ack_clr)) | evt;

  wire [31:0] rd_mux =
    hit(avs_address, OFF_COUNT_CTRL) ? {24'h0, count_reg} :
    hit(avs_address, OFF_SYSCLK_MODE) ? {28'h0, mode_reg} :
    hit(avs_address, OFF_IRQ_STATUS) ? {30'h0, stat_reg} :
    hit(avs_address, OFF_IRQ_MASK) ? {30'h0, mask_reg} :
    hit(avs_address, OFF_STOP_CTRL) ? {31'h0, stop_reg} : 32'h0;

  assign tk.sel = sel_reg;
  assign tk.run = ~stop_reg;

  itc_prescaler u_pre (
    .clk(clk),
    .resetn(resetn),
    .tk(tk)
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      bus_reg <= ITC_IDLE;
    else
    begin
      case (bus_reg)
        ITC_IDLE: if (avs_read | avs_write) bus_reg <= ITC_RESP;
        ITC_RESP: bus_reg <= ITC_IDLE;
        default: bus_reg <= ITC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rdata_reg <= 32'h0;
    else if (rd)
      rdata_reg <= rd_mux;
  end

  // counter: no enable bit exists, only clear and tick act on it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      count_reg <= 8'h00;
    else if (clr_reg)
      count_reg <= 8'h00;
    else if (tk.tick)
      count_reg <= count_reg + 8'h01;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_reg <= SEL_RESET;
      clr_reg <= 1'b0;
    end
    else if (wr_ctrl)
    begin
      sel_reg <= avs_writedata[SEL_MSB:SEL_LSB];
      clr_reg <= avs_writedata[CLR_BIT];
    end
    else
      clr_reg <= 1'b0;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_reg <= MODE_RESET;
      mask_reg <= '0;
      stat_reg <= '0;
    end
    else
    begin
      if (wr_mode)
        mode_reg <= avs_writedata[3:0];
      if (wr_mask)
        mask_reg <= avs_writedata[IRQ_W-1:0];
      stat_reg <= stat_next;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stop_sync_reg <= 3'h0;
      stop_reg <= 1'b0;
    end
    else
    begin
      stop_sync_reg <= {stop_sync_reg[1:0], stop_req};
      stop_reg <= stop_seen;
    end
  end

  // clock generator outputs and irq all registered; avs_waitrequest is decoded from bus_reg
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sub_clk_sel <= 1'b0;
      main_osc_en <= 1'b1;
      sys_clk_choice <= 2'h0;
      periph_clk_en <= 1'b1;
      taps_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      sub_clk_sel <= mode_reg[MODE_SUB_SEL];
      // the main oscillator may only stop while the sub clock drives the system
      main_osc_en <= ~(mode_reg[MODE_SUB_SEL] & mode_reg[MODE_MAIN_STOP]);
      sys_clk_choice <= mode_reg[3:2];
      periph_clk_en <= ~stop_reg;
      taps_reg <= tk.pdiv;
      irq_reg <= |(stat_next & mask_reg);
    end
  end

  assign periph_div_taps = taps_reg;
  assign irq = irq_reg;
  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = ~(bus_reg == ITC_RESP);
endmodule : itc_top
